// [hsfs_defines.vh]
// Constants for the hot-swap fault sequencer
`ifndef HSFS_DEFINES_VH
`define HSFS_DEFINES_VH
`define HSFS_CLK_HZ            10000000
`define HSFS_TB_US             1
`define HSFS_TB_DIV            ((`HSFS_CLK_HZ / 1000000) * `HSFS_TB_US)
`define HSFS_LOCKOUT_US        37500
`define HSFS_START_FIXED_US    9000
`define HSFS_START_MIN_US      400
`define HSFS_START_MAX_US      50000
`define HSFS_STATUS_US         750
`define HSFS_CLEAR_US          100
`define HSFS_SLOW_MAX_US       3000
`define HSFS_SLOW_MIN_US       110
`define HSFS_RETRY_MULT        64
`define HSFS_FAST_NS           260
`define HSFS_FAST_CYC          (((`HSFS_FAST_NS * (`HSFS_CLK_HZ / 1000000)) / 1000) > 0 ? \
	((`HSFS_FAST_NS * (`HSFS_CLK_HZ / 1000000)) / 1000) : 1)
`define HSFS_TRIP_X2           2'H1
`define HSFS_TRIP_X4           2'H2
`define HSFS_REG_CTRL          4'H0
`define HSFS_REG_START         4'H4
`define HSFS_REG_STATE         4'H8
`define HSFS_REG_IRQ_ST        4'HC
`define HSFS_REG_IRQ_MASK      5'H10
`define HSFS_CTRL_AUTORETRY    0
`define HSFS_CTRL_ADJUST       1
`define HSFS_IRQ_FAULT         0
`define HSFS_IRQ_GOOD          1
`define HSFS_IRQ_RETRY         2
`define HSFS_IRQ_W             3
`endif

// [hsfs_sequencer.v]
// Sequencing and fault logic of a dual-supply hot-swap controller
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "hsfs_defines.vh"
// Notes on behaviour
// RULE1: Startup lasts 9 ms fixed, or 0.4 to 50 ms when adjustable.
// RULE2: Startup waits for one supply above lockout for 37.5 ms continuously.
// RULE3: Startup also needs the turn-on request above its threshold.
// RULE4: No startup while latched off or waiting out the retry delay.
// RULE5: Slow overcurrent result is ignored throughout startup.
// RULE6: Fast overcurrent in startup regulates the gate at twice slow level.
// RULE7: Normal operation fast trip at four times slow level faults within 260 ns.
// RULE8: After startup enter normal; release status 0.75 ms later if fault free.
// RULE9: Sustained slow overcurrent faults after 110 us to 3 ms by overdrive.
// RULE10: Any normal-operation fault discharges both gates strongly and pulls status low.
// RULE11: Latched mode stays off until cleared; autoretry restarts by itself.
// RULE12: Latched clear: request low or one supply low for 100 us restarts.
// RULE13: Autoretry waits 64 startup periods with gates off, then restarts.
// RULE14: Dropping the request during retry wait neither clears nor shortens it.
// RULE15: A supply dropping low during retry wait cancels the remaining wait.
// RULE16: Both supplies low even briefly restarts lockout delay and full startup.
// RULE17: Gates stay off until lockout has been released.
// RULE18: Status low for request low, fault, lockout, startup, latched or retry.
// RULE19: All delays count from one time base; reset enters lockout state. The code counts the fast trip filter in clock cycles instead.
module hsfs_sequencer #(
	parameter LOCKOUT_US = `HSFS_LOCKOUT_US,
	parameter START_US   = `HSFS_START_FIXED_US,
	parameter STATUS_US  = `HSFS_STATUS_US,
	parameter CLEAR_US   = `HSFS_CLEAR_US,
	parameter TB_DIV     = `HSFS_TB_DIV
) (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        supply_first_ok,
	input  wire        supply_second_ok,
	input  wire        turn_on_above,
	input  wire        turn_on_below_low,
	input  wire        slow_overcurrent,
	input  wire        slow_overdrive_large,
	input  wire        fast_overcurrent,
	input  wire        voltage_fault,
	input  wire [4:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_we_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         pass_drive_first,
	output reg         pass_drive_second,
	output reg         gate_discharge,
	output reg         gate_regulate,
	output reg  [1:0]  fast_trip_select,
	output reg         supply_ok_status,
	output reg         irq
);
	localparam ST_LOCK   = 3'H0;
	localparam ST_WAIT   = 3'H1;
	localparam ST_START  = 3'H2;
	localparam ST_NORMAL = 3'H3;
	localparam ST_LATCH  = 3'H4;
	localparam ST_RETRY  = 3'H5;
	localparam CW = 32;
	// Slow filter bounds in time base ticks
	localparam [CW-1:0] SLOW_MAX = `HSFS_SLOW_MAX_US / `HSFS_TB_US;
	localparam [CW-1:0] SLOW_MIN = `HSFS_SLOW_MIN_US / `HSFS_TB_US;
	localparam          FAST_CYC_I = `HSFS_FAST_CYC;
	localparam [7:0]    FAST_CYC = FAST_CYC_I[7:0];

	// Microsecond figure to ticks, rounded up, at least one
	function [CW-1:0] hsfs_ticks;
		input [CW-1:0] us;
		begin
			hsfs_ticks = (us + `HSFS_TB_US - 1) / `HSFS_TB_US;
			if (hsfs_ticks == {CW{1'B0}})
				hsfs_ticks = {{(CW-1){1'B0}}, 1'B1};
		end
	endfunction

	// Two-flop synchronisers for comparator flags from the analog side
	reg [7:0] sync_a;
	reg [7:0] sync_b;
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync_a <= 8'H00;
			sync_b <= 8'H00;
		end
		else
		begin
			sync_a <= {voltage_fault, fast_overcurrent, slow_overdrive_large, slow_overcurrent,
				turn_on_below_low, turn_on_above, supply_second_ok, supply_first_ok};
			sync_b <= sync_a;
		end
	end
	wire s_in1  = sync_b[0];
	wire s_in2  = sync_b[1];
	wire s_on   = sync_b[2];
	wire s_off  = sync_b[3];
	wire s_slow = sync_b[4];
	wire s_big  = sync_b[5];
	wire s_fast = sync_b[6];
	wire s_volt = sync_b[7];
	wire any_ok = s_in1 | s_in2;
	// Only a rail that was up at the fault counts as dropped; an absent rail must not clear a fault
	reg  [1:0] up_mask;
	wire       rail_lost = |(up_mask & ~{s_in2, s_in1});

	// Software registers
	reg          ctrl_autoretry;
	reg          ctrl_adjust;
	reg [CW-1:0] start_sel_us;
	reg [`HSFS_IRQ_W-1:0] irq_status;
	reg [`HSFS_IRQ_W-1:0] irq_mask;
	reg [2:0]    state;

	// RULE19: one time base
	reg [7:0] tb_cnt;
	reg       tb_tick;
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tb_cnt <= 8'H00;
			tb_tick <= 1'B0;
		end
		else if (tb_cnt == TB_DIV[7:0] - 8'H01)
		begin
			tb_cnt <= 8'H00;
			tb_tick <= 1'B1;
		end
		else
		begin
			tb_cnt <= tb_cnt + 8'H01;
			tb_tick <= 1'B0;
		end
	end

	// RULE1: startup length, adjustable value clamped to its range
	reg [CW-1:0] start_ticks;
	always @*
	begin
		start_ticks = hsfs_ticks(START_US);
		if (ctrl_adjust)
		begin
			if (start_sel_us < `HSFS_START_MIN_US)
				start_ticks = hsfs_ticks(`HSFS_START_MIN_US);
			else if (start_sel_us > `HSFS_START_MAX_US)
				start_ticks = hsfs_ticks(`HSFS_START_MAX_US);
			else
				start_ticks = hsfs_ticks(start_sel_us);
		end
	end

	reg [CW-1:0] timer;
	reg [CW-1:0] clear_cnt;
	reg [CW-1:0] slow_cnt;
	reg [CW-1:0] good_cnt;
	reg [7:0]    fast_cnt;
	reg          good_done;
	reg          fault_evt;
	reg [CW-1:0] slow_limit;
	wire [CW-1:0] retry_ticks = start_ticks * `HSFS_RETRY_MULT;

	// RULE9: large overdrive picks the shorter filter bound, otherwise the longer one
	always @*
	begin
		slow_limit = s_big ? SLOW_MIN : SLOW_MAX;
	end

	// Main sequencer
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// RULE19: reset into lockout
			state <= ST_LOCK;
			timer <= {CW{1'B0}};
			clear_cnt <= {CW{1'B0}};
			slow_cnt <= {CW{1'B0}};
			good_cnt <= {CW{1'B0}};
			fast_cnt <= 8'H00;
			good_done <= 1'B0;
			fault_evt <= 1'B0;
			up_mask <= 2'H0;
		end
		else
		begin
			fault_evt <= 1'B0;
			// RULE16: both supplies low always restarts lockout
			if (!any_ok)
			begin
				state <= ST_LOCK;
				timer <= {CW{1'B0}};
			end
			else
			begin
				case (state)
				ST_LOCK:
				begin
					// RULE2: continuous lockout delay
					if (tb_tick)
						timer <= timer + 1'B1;
					if (timer >= hsfs_ticks(LOCKOUT_US))
					begin
						state <= ST_WAIT;
						timer <= {CW{1'B0}};
					end
				end
				ST_WAIT:
				begin
					// RULE3: request must be high
					if (s_on)
					begin
						state <= ST_START;
						timer <= {CW{1'B0}};
					end
				end
				ST_START:
				begin
					// RULE5: slow result ignored here
					if (tb_tick)
						timer <= timer + 1'B1;
					if (!s_on)
						state <= ST_WAIT;
					else if (timer >= start_ticks)
					begin
						// RULE8: enter normal operation
						state <= ST_NORMAL;
						timer <= {CW{1'B0}};
						good_cnt <= {CW{1'B0}};
						good_done <= 1'B0;
						slow_cnt <= {CW{1'B0}};
						fast_cnt <= 8'H00;
					end
				end
				ST_NORMAL:
				begin
					// RULE8: status release timer
					if (tb_tick && !good_done)
						good_cnt <= good_cnt + 1'B1;
					if (good_cnt >= hsfs_ticks(STATUS_US))
						good_done <= 1'B1;
					// RULE9: slow filter
					if (!s_slow)
						slow_cnt <= {CW{1'B0}};
					else if (tb_tick)
						slow_cnt <= slow_cnt + 1'B1;
					// RULE7: fast trip qualified over at most 260 ns
					if (!s_fast)
						fast_cnt <= 8'H00;
					else
						fast_cnt <= fast_cnt + 8'H01;
					if (!s_on)
						state <= ST_WAIT;
					else if ((s_fast && fast_cnt + 8'H01 >= FAST_CYC) || slow_cnt >= slow_limit ||
						s_volt)
					begin
						// RULE11: latched or autoretry recovery
						fault_evt <= 1'B1;
						state <= ctrl_autoretry ? ST_RETRY : ST_LATCH;
						up_mask <= {s_in2, s_in1};
						timer <= {CW{1'B0}};
						clear_cnt <= {CW{1'B0}};
					end
				end
				ST_LATCH:
				begin
					// RULE12: clear qualified for 100 us
					if (s_off || rail_lost)
					begin
						if (tb_tick)
							clear_cnt <= clear_cnt + 1'B1;
					end
					else
						clear_cnt <= {CW{1'B0}};
					if (clear_cnt >= hsfs_ticks(CLEAR_US))
						state <= ST_WAIT;
				end
				ST_RETRY:
				begin
					// RULE14: request level ignored while counting
					if (tb_tick)
						timer <= timer + 1'B1;
					// RULE15: supply drop cancels the wait
					if (rail_lost)
						state <= ST_WAIT;
					// RULE13: 64 startup periods
					else if (timer >= retry_ticks)
						state <= ST_WAIT;
				end
				default:
					state <= ST_LOCK;
				endcase
			end
		end
	end

	// Registered outputs
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pass_drive_first <= 1'B0;
			pass_drive_second <= 1'B0;
			gate_discharge <= 1'B1;
			gate_regulate <= 1'B0;
			fast_trip_select <= `HSFS_TRIP_X2;
			supply_ok_status <= 1'B0;
		end
		else
		begin
			// RULE17: gates only in startup or normal, never in lockout
			// RULE4: latch and retry keep gates off
			pass_drive_first <= (state == ST_START) || (state == ST_NORMAL);
			pass_drive_second <= (state == ST_START) || (state == ST_NORMAL);
			// RULE10: strong discharge whenever not driving
			gate_discharge <= !((state == ST_START) || (state == ST_NORMAL));
			// RULE6: fast result regulates during startup at twice slow level
			gate_regulate <= (state == ST_START) && s_fast;
			fast_trip_select <= (state == ST_NORMAL) ? `HSFS_TRIP_X4 : `HSFS_TRIP_X2;
			// RULE18: status low unless normal, released and clean
			supply_ok_status <= (state == ST_NORMAL) && good_done && s_on && !s_volt && !s_slow;
		end
	end

	// Wishbone slave with one wait state; sticky interrupt bits, set wins over clear
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
	wire [`HSFS_IRQ_W-1:0] irq_evt = {state == ST_RETRY && timer >= retry_ticks,
		supply_ok_status == 1'B0 && (state == ST_NORMAL) && good_done && s_on && !s_volt && !s_slow,
		fault_evt};
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wb_ack_o <= 1'B0;
			wb_dat_o <= 32'H00000000;
			ctrl_autoretry <= 1'B0;
			ctrl_adjust <= 1'B0;
			start_sel_us <= `HSFS_START_FIXED_US;
			irq_status <= {`HSFS_IRQ_W{1'B0}};
			irq_mask <= {`HSFS_IRQ_W{1'B0}};
			irq <= 1'B0;
		end
		else
		begin
			wb_ack_o <= wb_req;
			irq_status <= irq_status | irq_evt;
			if (wb_wr && wb_adr_i == {1'B0, `HSFS_REG_CTRL})
			begin
				ctrl_autoretry <= wb_dat_i[`HSFS_CTRL_AUTORETRY];
				ctrl_adjust <= wb_dat_i[`HSFS_CTRL_ADJUST];
			end
			else if (wb_wr && wb_adr_i == {1'B0, `HSFS_REG_START})
				start_sel_us <= wb_dat_i;
			else if (wb_wr && wb_adr_i == {1'B0, `HSFS_REG_IRQ_ST})
				irq_status <= (irq_status & ~wb_dat_i[`HSFS_IRQ_W-1:0]) | irq_evt;
			else if (wb_wr && wb_adr_i == `HSFS_REG_IRQ_MASK)
				irq_mask <= wb_dat_i[`HSFS_IRQ_W-1:0];
			// Read mux, unmapped reads as zero
			if (wb_adr_i == {1'B0, `HSFS_REG_CTRL})
				wb_dat_o <= {30'H0, ctrl_adjust, ctrl_autoretry};
			else if (wb_adr_i == {1'B0, `HSFS_REG_START})
				wb_dat_o <= start_sel_us;
			else if (wb_adr_i == {1'B0, `HSFS_REG_STATE})
				wb_dat_o <= {27'H0, supply_ok_status, pass_drive_first, state};
			else if (wb_adr_i == {1'B0, `HSFS_REG_IRQ_ST})
				wb_dat_o <= {29'H0, irq_status};
			else if (wb_adr_i == `HSFS_REG_IRQ_MASK)
				wb_dat_o <= {29'H0, irq_mask};
			else
				wb_dat_o <= 32'H00000000;
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule
`default_nettype wire

// [hsfs_rail_model.sv]
// Model of the pass transistors, load and backplane rails
`timescale 1ns/10ps
`default_nettype none
module hsfs_rail_model (
	input  wire logic       clock,
	input  wire logic [1:0] rail_on,
	input  wire logic [1:0] load,
	input  wire logic       pass_drive_first,
	output var  logic       supply_first_ok = 1'H0,
	output var  logic       supply_second_ok = 1'H0,
	output var  logic       slow_overcurrent = 1'H0,
	output var  logic       slow_overdrive_large = 1'H0,
	output var  logic       fast_overcurrent = 1'H0
);
	// Overcurrent flags rise only while the first gate conducts; the overdrive flag follows load[1] alone; load 3 is a dead short
	always @(posedge clock)
	begin
		supply_first_ok      <= rail_on[0];
		supply_second_ok     <= rail_on[1];
		slow_overcurrent     <= pass_drive_first && load != 2'H0;
		slow_overdrive_large <= load[1];
		fast_overcurrent     <= pass_drive_first && load == 2'H3;
	end
endmodule
`default_nettype wire

// [hsfs_seq_properties.sv]
// Port-level properties of the hot-swap fault sequencer
`timescale 1ns/10ps
`default_nettype none
`include "hsfs_defines.vh"
module hsfs_seq_props (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       supply_first_ok,
	input wire logic       supply_second_ok,
	input wire logic       turn_on_above,
	input wire logic       slow_overcurrent,
	input wire logic       fast_overcurrent,
	input wire logic       pass_drive_first,
	input wire logic       pass_drive_second,
	input wire logic       gate_discharge,
	input wire logic       gate_regulate,
	input wire logic [1:0] fast_trip_select,
	input wire logic       supply_ok_status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	AST_LOCK_GATES: assert property ((!supply_first_ok && !supply_second_ok) [*4] |=> !pass_drive_first)
		else $error("gates driven while both supplies low");
	AST_GATE_PAIR: assert property (pass_drive_first == pass_drive_second)
		else $error("gate drives differ");
	AST_DISCH_OFF: assert property (gate_discharge |-> !pass_drive_first && !pass_drive_second)
		else $error("gate driven during discharge");
	AST_STATUS_NORMAL: assert property (supply_ok_status |-> pass_drive_first && fast_trip_select == `HSFS_TRIP_X4)
		else $error("status released outside normal operation");
	AST_REQ_STATUS: assert property ((!turn_on_above) [*4] |-> !supply_ok_status)
		else $error("status released with request low");
	AST_FAST_TRIP: assert property (pass_drive_first && fast_trip_select == `HSFS_TRIP_X4 && fast_overcurrent
		|-> ##[1:5] gate_discharge)
		else $error("fast overcurrent not turned into a fault");
	// slow ignored in startup; leaving on request or supply loss is no fault
	AST_START_NOFAULT: assert property ((turn_on_above && (supply_first_ok || supply_second_ok)) [*4]
		##0 (pass_drive_first && fast_trip_select == `HSFS_TRIP_X2) |=> !gate_discharge)
		else $error("fault raised during startup");
	AST_REGULATE: assert property (gate_regulate |-> pass_drive_first && fast_trip_select == `HSFS_TRIP_X2)
		else $error("regulation outside startup");
	AST_SLOW_FILTER: assert property ($rose(slow_overcurrent) && !fast_overcurrent && pass_drive_first
		|=> pass_drive_first [*8])
		else $error("slow overcurrent not filtered");
	COV_REGULATE: cover property (gate_regulate);
	COV_STATUS: cover property ($rose(supply_ok_status));
	COV_FAULT: cover property ($rose(gate_discharge));
endmodule
bind hsfs_sequencer hsfs_seq_props chk_u (.*);
`default_nettype wire

// [hot_swap_fault_sequencer_tb_top.sv]
// Self-checking bench for the hot-swap fault sequencer
`timescale 1ns/10ps
`default_nettype none
`include "hsfs_defines.vh"
module hot_swap_fault_sequencer_tb_top;
	logic        clock = 1'H0;
	logic        rst_b = 1'H0;
	logic [1:0]  rail_on = 2'H0;
	logic [1:0]  load = 2'H0;
	logic        turn_on_above = 1'H0;
	logic        turn_on_below_low = 1'H1;
	logic        voltage_fault = 1'H0;
	logic [4:0]  wb_adr_i = 5'H0;
	logic [31:0] wb_dat_i = 32'H0;
	logic [3:0]  wb_sel_i = 4'HF;
	logic        wb_we_i = 1'H0;
	logic        wb_cyc_i = 1'H0;
	logic        wb_stb_i = 1'H0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, pass_drive_first, pass_drive_second, gate_discharge, gate_regulate;
	logic [1:0]  fast_trip_select;
	logic        supply_ok_status, irq;
	logic        supply_first_ok, supply_second_ok, slow_overcurrent, slow_overdrive_large, fast_overcurrent;
	int          n_mismatch = 0;
	int          checks = 0;
	// Short counts keep the run brief; time base stays 1 us
	hsfs_sequencer #(.LOCKOUT_US(50), .START_US(20), .STATUS_US(10), .CLEAR_US(5)) dut_u (.*);
	hsfs_rail_model rail_u (.*);
	// 10 MHz clock
	initial
	begin
		forever #50 clock = ~clock;
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, got);
		end
	endtask
	// One classic cycle; the master holds everything until ack is sampled
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc_i <= 1'H1;
		wb_stb_i <= 1'H1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'H1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'H0;
		wb_stb_i <= 1'H0;
		if (n >= 20)
		begin
			n_mismatch++;
			summarize;
		end
	endtask
	// Bounded wait: s selects gate drive, status or discharge
	task automatic waitc(input int s, input logic v, input int lim);
		int n;
		n = 0;
		while ((s == 0 ? pass_drive_first : s == 1 ? supply_ok_status : gate_discharge) !== v)
		begin
			@(posedge clock);
			n++;
			if (n > lim)
			begin
				n_mismatch++;
				summarize;
			end
		end
	endtask
	task automatic state_is(input logic [2:0] e);
		logic [31:0] q;
		bus(1'H0, `HSFS_REG_STATE, 32'H0, q);
		chk("state", q & 32'H7, {29'H0, e});
	endtask
	// Main sequence
	initial
	begin
		logic [31:0] q;
		repeat (4) @(posedge clock);
		rst_b <= 1'H1;
		state_is(3'H0);
		rail_on <= 2'H1;
		turn_on_above <= 1'H1;
		turn_on_below_low <= 1'H0;
		repeat (400) @(posedge clock);
		chk("gate", pass_drive_first, 1'H0);
		waitc(0, 1'H1, 300);
		chk("trip", fast_trip_select, `HSFS_TRIP_X2);
		waitc(1, 1'H1, 400);
		state_is(3'H3);
		chk("trip", fast_trip_select, `HSFS_TRIP_X4);
		$display("test power-up done");
		load <= 2'H2;
		waitc(2, 1'H1, 3000);
		chk("status", supply_ok_status, 1'H0);
		load <= 2'H0;
		repeat (2000) @(posedge clock);
		state_is(3'H4);
		bus(1'H1, `HSFS_REG_IRQ_MASK, 32'H1, q);
		repeat (3) @(posedge clock);
		chk("irq", irq, 1'H1);
		bus(1'H1, `HSFS_REG_IRQ_ST, 32'H1, q);
		repeat (3) @(posedge clock);
		chk("irq", irq, 1'H0);
		bus(1'H0, 5'H14, 32'H0, q);
		chk("unmapped", q, 32'H0);
		$display("test latched fault done");
		turn_on_above <= 1'H0;
		turn_on_below_low <= 1'H1;
		repeat (100) @(posedge clock);
		turn_on_above <= 1'H1;
		turn_on_below_low <= 1'H0;
		bus(1'H1, `HSFS_REG_CTRL, 32'H1, q);
		waitc(0, 1'H1, 100);
		load <= 2'H3;
		repeat (10) @(posedge clock);
		chk("regulate", gate_regulate, 1'H1);
		chk("discharge", gate_discharge, 1'H0);
		waitc(2, 1'H1, 400);
		load <= 2'H0;
		state_is(3'H5);
		turn_on_above <= 1'H0;
		turn_on_below_low <= 1'H1;
		repeat (200) @(posedge clock);
		turn_on_above <= 1'H1;
		turn_on_below_low <= 1'H0;
		state_is(3'H5);
		rail_on <= 2'H2;
		repeat (20) @(posedge clock);
		rail_on <= 2'H3;
		waitc(0, 1'H1, 100);
		rail_on <= 2'H0;
		repeat (20) @(posedge clock);
		rail_on <= 2'H3;
		repeat (400) @(posedge clock);
		chk("gate", pass_drive_first, 1'H0);
		waitc(0, 1'H1, 300);
		$display("test autoretry done");
		// Output window fault in normal operation, then the full retry wait
		waitc(1, 1'H1, 400);
		voltage_fault <= 1'H1;
		waitc(2, 1'H1, 20);
		chk("status", supply_ok_status, 1'H0);
		voltage_fault <= 1'H0;
		repeat (12000) @(posedge clock);
		chk("gate", pass_drive_first, 1'H0);
		waitc(0, 1'H1, 1200);
		bus(1'H0, {1'H0, `HSFS_REG_IRQ_ST}, 32'H0, q);
		chk("retry irq", q & 32'H4, 32'H4);
		$display("test retry expiry done");
		// Adjustable startup below range is clamped to 400 us
		turn_on_above <= 1'H0;
		turn_on_below_low <= 1'H1;
		bus(1'H1, {1'H0, `HSFS_REG_START}, 32'H0, q);
		bus(1'H1, {1'H0, `HSFS_REG_CTRL}, 32'H3, q);
		turn_on_above <= 1'H1;
		turn_on_below_low <= 1'H0;
		waitc(0, 1'H1, 100);
		repeat (3900) @(posedge clock);
		chk("trip", fast_trip_select, `HSFS_TRIP_X2);
		repeat (200) @(posedge clock);
		chk("trip", fast_trip_select, `HSFS_TRIP_X4);
		$display("test adjustable startup done");
		summarize;
	end
endmodule
`default_nettype wire
